// ---- core/uart_status_pkg.sv ----
// constants, field layout and types for the uart channel status block
package uart_status_pkg;

    // register byte addresses on the apb side
    localparam logic [7:0]  ADDR_MODE     = 8'h00;
    localparam logic [7:0]  ADDR_STATUS   = 8'h04;
    localparam logic [7:0]  ADDR_CMD      = 8'h08;
    localparam logic [7:0]  ADDR_DATA     = 8'h0C;
    localparam logic [7:0]  ADDR_DIV      = 8'h10;

    // mode_register_one layout: [1:0] length, [2] parity type, [4:3] parity_mode_field
    localparam int          MODE_LEN_LSB  = 0;
    localparam int          MODE_PT_BIT   = 2;
    localparam int          MODE_PM_LSB   = 3;
    localparam logic [4:0]  MODE_RESET    = 5'h13;
    localparam logic [15:0] DIV_RESET     = 16'h000A;

    // channel_command_register layout
    localparam int          CMD_RX_LSB    = 0;
    localparam int          CMD_TC_LSB    = 2;
    localparam int          CMD_MISC_LSB  = 4;
    localparam logic [1:0]  CTL_ENABLE    = 2'h1;
    localparam logic [1:0]  CTL_DISABLE   = 2'h2;
    localparam logic [2:0]  CMD_RST_RX    = 3'h2;
    localparam logic [2:0]  CMD_RST_TX    = 3'h3;
    localparam logic [2:0]  CMD_RST_ERR   = 3'h4;

    // parity_mode_field codes
    localparam logic [1:0]  PM_WITH       = 2'h0;
    localparam logic [1:0]  PM_FORCE      = 2'h1;
    localparam logic [1:0]  PM_NONE       = 2'h2;
    localparam logic [1:0]  PM_MULTI      = 2'h3;

    // uart_channel_status bit positions
    localparam int          ST_BRK        = 7;
    localparam int          ST_FE         = 6;
    localparam int          ST_PE         = 5;
    localparam int          ST_OE         = 4;
    localparam int          ST_TRANSMITTER_EMPTY_FLAG      = 3;
    localparam int          ST_TRANSMITTER_READY_FLAG      = 2;
    localparam int          ST_FULL       = 1;
    localparam int          ST_RECEIVER_READY_FLAG      = 0;

    // timing in uart clock ticks (16x oversampling)
    localparam logic [3:0]  MID_TICK      = 4'h7;
    localparam logic [3:0]  LAST_TICK     = 4'hF;
    localparam logic [3:0]  HALF_BIT_TICKS = 4'h8;
    localparam logic [1:0]  FIFO_DEPTH    = 2'h3;
    localparam logic [1:0]  FIFO_LAST     = 2'h2;

    typedef struct packed {
        logic       brk;
        logic       fe;
        logic       pe;
        logic [7:0] data;
    } rx_entry_t;

endpackage : uart_status_pkg

// ---- core/bit_sync.sv ----
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module bit_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic sys_clk,
    input  wire logic srst,
    input  wire logic asyncIn,
    output logic      syncOut
);
    logic meta_q;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            meta_q  <= RESET_VAL;
            syncOut <= RESET_VAL;
        end else begin
            meta_q  <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule : bit_sync

// ---- core/rx_fifo.sv ----
// three-entry receive fifo holding characters with their status
`timescale 1ns/1ps
module rx_fifo (
    input  wire logic                      sys_clk,
    input  wire logic                      srst,
    input  wire logic                      flush,
    input  wire logic                      clrErr,
    input  wire logic                      push,
    input  wire uart_status_pkg::rx_entry_t pushData,
    input  wire logic                      pop,
    output uart_status_pkg::rx_entry_t     head,
    output logic [1:0]                     count
);
    import uart_status_pkg::*;

    rx_entry_t  mem_q [3];
    logic [1:0] wrPtr_q;
    logic [1:0] rdPtr_q;
    logic [1:0] count_q;
    logic       doPush;
    logic       doPop;

    assign doPush = push && (count_q != FIFO_DEPTH);
    assign doPop  = pop && (count_q != 2'h0);
    assign head   = mem_q[rdPtr_q];
    assign count  = count_q;

    always_ff @(posedge sys_clk) begin
        if (srst || flush) begin
            wrPtr_q <= 2'h0;
            rdPtr_q <= 2'h0;
            count_q <= 2'h0;
        end else begin
            if (doPush) begin
                wrPtr_q <= (wrPtr_q == FIFO_LAST) ? 2'h0 : wrPtr_q + 2'h1;
            end
            if (doPop) begin
                rdPtr_q <= (rdPtr_q == FIFO_LAST) ? 2'h0 : rdPtr_q + 2'h1;
            end
            count_q <= count_q + {1'b0, doPush} - {1'b0, doPop};
        end
    end

    // error clear first, so a character written in the same cycle keeps its flags
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < 3; i++) begin
            if (clrErr) begin
                mem_q[i].brk <= 1'b0;
                mem_q[i].fe  <= 1'b0;
                mem_q[i].pe  <= 1'b0;
            end
        end
        if (doPush) begin
            mem_q[wrPtr_q] <= pushData;
        end
    end
endmodule : rx_fifo

// ---- core/uart_status_flags.sv ----
// one uart channel with apb registers, receive fifo and status flags
`timescale 1ns/1ps
module uart_status_flags (
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        serial_receive_line,
    output logic             serialTransmitLine
);
    import uart_status_pkg::*;

    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK} rx_state_t;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;

    // ---------------- apb slave ----------------
    logic        setupPhase;
    logic        accessDone;
    logic        apbWrite;
    logic        apbRead;
    logic        hitMode;
    logic        hitStatus;
    logic        hitCmd;
    logic        hitData;
    logic        hitDiv;
    logic        addrHit;
    logic [31:0] readMux;
    logic [7:0]  uart_channel_status;

    assign setupPhase = psel && !penable;
    assign accessDone = psel && penable && pready;
    assign apbWrite   = accessDone && pwrite;
    assign apbRead    = accessDone && !pwrite;
    assign hitMode    = paddr == ADDR_MODE;
    assign hitStatus  = paddr == ADDR_STATUS;
    assign hitCmd     = paddr == ADDR_CMD;
    assign hitData    = paddr == ADDR_DATA;
    assign hitDiv     = paddr == ADDR_DIV;
    assign addrHit    = hitMode || hitStatus || hitCmd || hitData || hitDiv;

    // registers
    logic [4:0]  mode_register_one;
    logic [15:0] divisor_q;
    logic [15:0] divCnt_q;
    logic        rxEn_q;
    logic        txEn_q;
    logic        overrun_q;

    // command decode, effective at the completing access edge
    logic        cmdWrite;
    logic [1:0]  rxCtl;
    logic [1:0]  transmitter_control_field;
    logic [2:0]  miscCmd;
    logic        rstRx;
    logic        rstTx;
    logic        rstErr;
    logic        txEnable;
    logic        txDisable;

    assign cmdWrite  = apbWrite && hitCmd;
    assign rxCtl     = pwdata[CMD_RX_LSB +: 2];
    assign transmitter_control_field = pwdata[CMD_TC_LSB +: 2];
    assign miscCmd   = pwdata[CMD_MISC_LSB +: 3];
    assign rstRx     = cmdWrite && (miscCmd == CMD_RST_RX);
    assign rstTx     = cmdWrite && (miscCmd == CMD_RST_TX);
    assign rstErr    = cmdWrite && (miscCmd == CMD_RST_ERR);
    assign txEnable  = cmdWrite && (transmitter_control_field == CTL_ENABLE);
    assign txDisable = cmdWrite && (transmitter_control_field == CTL_DISABLE);

    logic [1:0] parity_mode_field;
    logic       parityType;
    logic [1:0] charLen;
    logic [2:0] lastBit;
    logic       parityOn;

    assign parity_mode_field = mode_register_one[MODE_PM_LSB +: 2];
    assign parityType = mode_register_one[MODE_PT_BIT];
    assign charLen    = mode_register_one[MODE_LEN_LSB +: 2];
    assign lastBit    = {1'b0, charLen} + 3'h4;
    assign parityOn   = parity_mode_field != PM_NONE;

    // ---------------- uart clock tick ----------------
    logic tick;

    assign tick = divCnt_q == 16'h0000;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            divCnt_q <= DIV_RESET;
        end else begin
            divCnt_q <= tick ? divisor_q : divCnt_q - 16'h0001;
        end
    end

    // ---------------- receiver ----------------
    logic       rxLine;
    rx_state_t  rxState_q;
    logic [3:0] rxSub_q;
    logic [2:0] rxBit_q;
    logic [7:0] rxShift_q;
    logic       rxParBit_q;
    logic [3:0] hiCnt_q;
    logic       rxMid;
    logic       charDone;
    logic [7:0] rxData;
    logic       rxBreak;
    logic       rxFraming;
    logic       rxParErr;
    rx_entry_t  newEntry;

    bit_sync #(.RESET_VAL(1'b1)) rxSync (
        .sys_clk (sys_clk),
        .srst    (srst),
        .asyncIn (serial_receive_line),
        .syncOut (rxLine)
    );

    assign rxMid    = tick && (rxSub_q == MID_TICK);
    assign charDone = rxMid && (rxState_q == RX_STOP);
    assign rxData   = rxShift_q >> (2'h3 - charLen);
    // stop bit checked at its middle
    assign rxFraming = !rxLine;
    // all-zero char, zero parity, no stop
    assign rxBreak  = (rxData == 8'h00) && !(parityOn && rxParBit_q) && !rxLine;
    assign rxParErr = (parity_mode_field == PM_MULTI) ? rxParBit_q :
                      (parity_mode_field == PM_WITH)  ? ((^rxData ^ rxParBit_q) != parityType) :
                      (parity_mode_field == PM_FORCE) ? (rxParBit_q != parityType) : 1'b0;
    assign newEntry = '{brk: rxBreak, fe: rxFraming, pe: rxParErr, data: rxData};

    // each new start bit begins a fresh character time
    always_ff @(posedge sys_clk) begin
        if (srst || rstRx) begin
            rxState_q <= RX_IDLE;
            rxSub_q   <= 4'h0;
            rxBit_q   <= 3'h0;
            hiCnt_q   <= 4'h0;
        end else if (tick) begin
            rxSub_q <= rxSub_q + 4'h1;
            case (rxState_q)
                RX_IDLE: begin
                    rxSub_q <= 4'h0;
                    if (rxEn_q && !rxLine) begin
                        rxState_q <= RX_START;
                    end
                end
                RX_START: if (rxSub_q == MID_TICK) begin
                    rxBit_q   <= 3'h0;
                    rxState_q <= rxLine ? RX_IDLE : RX_DATA;
                end
                RX_DATA: if (rxSub_q == MID_TICK) begin
                    rxShift_q <= {rxLine, rxShift_q[7:1]};
                    rxBit_q   <= rxBit_q + 3'h1;
                    if (rxBit_q == lastBit) begin
                        rxState_q <= parityOn ? RX_PAR : RX_STOP;
                    end
                end
                RX_PAR: if (rxSub_q == MID_TICK) begin
                    rxParBit_q <= rxLine;
                    rxState_q  <= RX_STOP;
                end
                RX_STOP: if (rxSub_q == MID_TICK) begin
                    hiCnt_q   <= 4'h0;
                    // hold off new entries after a break
                    rxState_q <= rxBreak ? RX_BRK : RX_IDLE;
                end
                RX_BRK: begin
                    // line high for half a bit
                    hiCnt_q <= rxLine ? hiCnt_q + 4'h1 : 4'h0;
                    if (rxLine && (hiCnt_q == HALF_BIT_TICKS - 4'h1)) begin
                        rxState_q <= RX_IDLE;
                    end
                end
                default: rxState_q <= RX_IDLE;
            endcase
        end
    end

    // ---------------- holding stage and fifo ----------------
    rx_entry_t  hold_q;
    logic       holdValid_q;
    rx_entry_t  fifoHead;
    logic [1:0] fifoCount;
    logic       fifoFull;
    logic       fifoEmpty;
    logic       pushReq;
    logic       loadHold;
    logic       overrunEvt;
    logic       popReq;

    // full only with three unread characters
    assign fifoFull   = fifoCount == FIFO_DEPTH;
    assign fifoEmpty  = fifoCount == 2'h0;
    assign pushReq    = (holdValid_q || charDone) && !fifoFull;
    assign loadHold   = charDone && (holdValid_q || fifoFull);
    // new char with fifo and holder both occupied
    assign overrunEvt = charDone && holdValid_q && fifoFull;
    assign popReq     = apbRead && hitData;

    // held character overwritten, its status lost with it
    always_ff @(posedge sys_clk) begin
        if (srst || rstRx) begin
            holdValid_q <= 1'b0;
        end else begin
            holdValid_q <= loadHold || (holdValid_q && fifoFull);
        end
        if (loadHold) begin
            hold_q <= newEntry;
        end
    end

    rx_fifo rxFifo (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .flush    (rstRx),
        .clrErr   (rstErr),
        .push     (pushReq),
        .pushData (holdValid_q ? hold_q : newEntry),
        .pop      (popReq),
        .head     (fifoHead),
        .count    (fifoCount)
    );

    // overrun sticky, error reset clears, a new overrun wins
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            overrun_q <= 1'b0;
        end else if (overrunEvt) begin
            overrun_q <= 1'b1;
        end else if (rstErr) begin
            overrun_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst || rstRx) begin
            rxEn_q <= 1'b0;
        end else if (cmdWrite && rxCtl == CTL_ENABLE) begin
            rxEn_q <= 1'b1;
        end else if (cmdWrite && rxCtl == CTL_DISABLE) begin
            rxEn_q <= 1'b0;
        end
    end

    // ---------------- transmitter ----------------
    tx_state_t  txState_q;
    logic [3:0] txSub_q;
    logic [2:0] txBit_q;
    logic [7:0] txShift_q;
    logic       txParBit_q;
    logic [7:0] thr_q;
    logic       thrValid_q;
    logic       transmitter_ready_flag_q;
    logic       transmitter_empty_flag_q;
    logic       thrWrite;
    logic       txLoad;
    logic       bitEnd;
    logic       lastStop;
    logic       txLineNext;

    // a write while disabled never reaches the holder
    assign thrWrite = apbWrite && hitData && txEn_q;
    // loading waits one cycle on a write so ready never sees set and clear at once
    assign txLoad   = (txState_q == TX_IDLE) && thrValid_q && !thrWrite;
    assign bitEnd   = tick && (txSub_q == LAST_TICK);
    assign lastStop = bitEnd && (txState_q == TX_STOP);
    assign txLineNext = (txState_q == TX_START) ? 1'b0 :
                        (txState_q == TX_DATA)  ? txShift_q[0] :
                        (txState_q == TX_PAR)   ? txParBit_q : 1'b1;

    always_ff @(posedge sys_clk) begin
        if (srst || rstTx) begin
            txState_q  <= TX_IDLE;
            thrValid_q <= 1'b0;
            txSub_q    <= 4'h0;
        end else begin
            if (thrWrite) begin
                thr_q      <= pwdata[7:0];
                thrValid_q <= 1'b1;
            end else if (txLoad) begin
                thrValid_q <= 1'b0;
            end
            if (tick) begin
                txSub_q <= txSub_q + 4'h1;
            end
            case (txState_q)
                TX_IDLE: if (txLoad) begin
                    txShift_q  <= thr_q;
                    txParBit_q <= (parity_mode_field == PM_WITH) ?
                                  (^(thr_q & (8'hFF >> (2'h3 - charLen))) ^ parityType) :
                                  parityType;
                    txSub_q    <= 4'h0;
                    txBit_q    <= 3'h0;
                    txState_q  <= TX_START;
                end
                TX_START: if (bitEnd) begin
                    txState_q <= TX_DATA;
                end
                TX_DATA: if (bitEnd) begin
                    txShift_q <= {1'b0, txShift_q[7:1]};
                    txBit_q   <= txBit_q + 3'h1;
                    if (txBit_q == lastBit) begin
                        txState_q <= parityOn ? TX_PAR : TX_STOP;
                    end
                end
                TX_PAR: if (bitEnd) begin
                    txState_q <= TX_STOP;
                end
                TX_STOP: if (bitEnd) begin
                    txState_q <= TX_IDLE;
                end
                default: txState_q <= TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst || rstTx || txDisable) begin
            txEn_q  <= 1'b0;
            transmitter_ready_flag_q <= 1'b0;
        end else if (txEnable && !txEn_q) begin
            txEn_q  <= 1'b1;
            transmitter_ready_flag_q <= 1'b1;
        end else if (thrWrite) begin
            transmitter_ready_flag_q <= 1'b0;
        end else if (txLoad && txEn_q) begin
            transmitter_ready_flag_q <= 1'b1;
        end
    end

    // empty only after final stop with nothing pending
    always_ff @(posedge sys_clk) begin
        if (srst || rstTx) begin
            transmitter_empty_flag_q <= 1'b0;
        end else if (txLoad || thrWrite) begin
            transmitter_empty_flag_q <= 1'b0;
        end else if (lastStop && !thrValid_q) begin
            transmitter_empty_flag_q <= 1'b1;
        end
    end

    // ---------------- status and register file ----------------
    // head flags shown only while a character waits
    assign uart_channel_status = {fifoHead.brk && !fifoEmpty,
                                  fifoHead.fe && !fifoEmpty,
                                  fifoHead.pe && !fifoEmpty,
                                  overrun_q,
                                  transmitter_empty_flag_q && txEn_q,
                                  transmitter_ready_flag_q && txEn_q,
                                  fifoFull,
                                  !fifoEmpty};

    assign readMux = hitMode   ? {27'h000_0000, mode_register_one} :
                     hitStatus ? {24'h00_0000, uart_channel_status} :
                     hitData   ? {24'h00_0000, fifoEmpty ? 8'h00 : fifoHead.data} :
                     hitDiv    ? {16'h0000, divisor_q} : 32'h0000_0000;

    // status has no write path and its read pops nothing
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mode_register_one <= MODE_RESET;
            divisor_q         <= DIV_RESET;
        end else if (apbWrite && hitMode) begin
            mode_register_one <= pwdata[4:0];
        end else if (apbWrite && hitDiv) begin
            divisor_q         <= pwdata[15:0];
        end
    end

    // one registered answer cycle: pready rises in the first access cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pready             <= 1'b0;
            pslverr            <= 1'b0;
            prdata             <= 32'h0000_0000;
            serialTransmitLine <= 1'b1;
        end else begin
            pready             <= setupPhase;
            pslverr            <= setupPhase && !addrHit;
            serialTransmitLine <= txLineNext;
            if (setupPhase) begin
                prdata <= pwrite ? 32'h0000_0000 : readMux;
            end
        end
    end
endmodule : uart_status_flags

// ---- sim/uart_status_flags_monitor.sv ----
// concurrent checks on the ports of the uart status block
`timescale 1ns/1ps
module uart_status_flags_monitor (
    input wire logic        sys_clk,
    input wire logic        srst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        serial_receive_line,
    input wire logic        serialTransmitLine
);
    import uart_status_pkg::*;
    wire rdSt = psel && penable && pready && !pwrite && paddr == ADDR_STATUS;
    wire setup = psel && !penable;
    wire mapped = paddr[7:5] == 3'h0 && paddr[1:0] == 2'h0 && paddr[4:2] <= 3'h4;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    ready_timely_a: assert property (setup |=> pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    unmapped_err_a: assert property (setup && !mapped |=> pslverr)
        else $error("unmapped address not refused");
    mapped_ok_a: assert property (setup && mapped |=> !pslverr)
        else $error("mapped address refused");
    status_upper_a: assert property (rdSt |-> prdata[31:8] == 24'h00_0000)
        else $error("status upper bits set");
    flag_valid_a: assert property (rdSt && !prdata[ST_RECEIVER_READY_FLAG] |-> prdata[7:5] == 3'h0)
        else $error("error flags without data");
    full_ready_a: assert property (rdSt && prdata[ST_FULL] |-> prdata[ST_RECEIVER_READY_FLAG])
        else $error("full without ready");
    tx_busy_a: assert property (rdSt && !$past(serialTransmitLine) |-> !prdata[ST_TRANSMITTER_EMPTY_FLAG])
        else $error("empty while shifting");
    cover property (rdSt && prdata[ST_FULL]);
    cover property (rdSt && prdata[ST_OE]);
    cover property (pslverr);
endmodule : uart_status_flags_monitor

bind uart_status_flags uart_status_flags_monitor mon_u (.sys_clk, .srst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .serial_receive_line,
    .serialTransmitLine);

// ---- sim/serial_partner.sv ----
// remote serial partner: drives the receive line, decodes the transmit line
`timescale 1ns/1ps
module serial_partner (
    input  wire logic sys_clk,
    input  wire logic txLine,
    output logic      rxLine
);
    logic [7:0] txByte = 8'h00;
    int         txCount = 0;
    initial rxLine = 1'b1;
    // start bit, then n bits lsb first; 16 cycles a bit at divisor 0
    task automatic send(input logic [10:0] f, input int n);
        @(posedge sys_clk);
        rxLine <= 1'b0;
        repeat (16) @(posedge sys_clk);
        for (int i = 0; i < n; i++) begin
            rxLine <= f[i];
            repeat (16) @(posedge sys_clk);
        end
        rxLine <= 1'b1;
        repeat (32) @(posedge sys_clk);
    endtask : send
    // sample mid bit so edge jitter of one cycle is harmless
    always @(negedge txLine) begin
        repeat (8) @(posedge sys_clk);
        if (!txLine) begin
            for (int i = 0; i < 8; i++) begin
                repeat (16) @(posedge sys_clk);
                txByte[i] = txLine;
            end
            txCount++;
        end
    end
endmodule : serial_partner

// ---- sim/uart_status_flags_tb.sv ----
// bench for the uart status block: apb sequences and serial traffic
`timescale 1ns/1ps
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin errTotal++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module uart_status_flags_tb;
    import uart_status_pkg::*;
    logic        sys_clk = 1'b0;
    logic        srst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, rxLine, txLine, er, pe0;
    logic [7:0]  exp [4] = '{8'h11, 8'h22, 8'h33, 8'h55};
    logic [1:0]  pm [3] = '{PM_WITH, PM_FORCE, PM_MULTI};
    int          errTotal = 0;
    int          nChecks = 0;
    int          cyc = 0;
    always #25 sys_clk = ~sys_clk;
    uart_status_flags dut_u (.sys_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .serial_receive_line(rxLine), .serialTransmitLine(txLine));
    serial_partner far_u (.sys_clk, .txLine, .rxLine);
    task automatic closeOut;
        $display("checks=%0d errors=%0d", nChecks, errTotal);
        if (errTotal == 0 && nChecks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : closeOut
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            errTotal++;
            closeOut();
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chkSt(input logic [7:0] m, input logic [7:0] e);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000);
        `CHK(rd[7:0] & m, e)
    endtask : chkSt
    initial begin
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        chkSt(8'hFF, 8'h00);
        apb(1'b0, 8'h14, 32'h0000_0000);
        `CHK({er, rd}, {1'b1, 32'h0000_0000})
        apb(1'b1, ADDR_STATUS, 32'h0000_00FF);
        chkSt(8'hFF, 8'h00);
        apb(1'b1, ADDR_DIV, 32'h0000_0000);
        apb(1'b1, ADDR_DATA, 32'h0000_0033);
        apb(1'b1, ADDR_CMD, 32'h0000_0005);
        chkSt(8'h04, 8'h04);
        repeat (250) @(posedge sys_clk);
        `CHK(far_u.txCount, 0)
        apb(1'b1, ADDR_DATA, 32'h0000_00A6);
        chkSt(8'h08, 8'h00);
        chkSt(8'h0C, 8'h04);
        repeat (250) @(posedge sys_clk);
        chkSt(8'h0C, 8'h0C);
        `CHK(far_u.txByte, 8'hA6)
        apb(1'b1, ADDR_DATA, 32'h0000_005A);
        apb(1'b1, ADDR_DATA, 32'h0000_00C3);
        chkSt(8'h04, 8'h00);
        for (int i = 1; i < 6; i++) far_u.send({3'h1, 8'(i * 17)}, 9);
        chkSt(8'h13, 8'h13);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, ADDR_DATA, 32'h0000_0000);
            `CHK(rd[7:0], exp[i])
            if (i == 1) chkSt(8'h02, 8'h00);
        end
        chkSt(8'h11, 8'h10);
        apb(1'b1, ADDR_CMD, 32'h0000_0040);
        chkSt(8'h10, 8'h00);
        far_u.send(11'h000, 9);
        chkSt(8'hC1, 8'hC1);
        apb(1'b0, ADDR_DATA, 32'h0000_0000);
        chkSt(8'h01, 8'h00);
        far_u.send(11'h0A5, 9);
        chkSt(8'hC1, 8'h41);
        apb(1'b0, ADDR_DATA, 32'h0000_0000);
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, ADDR_MODE, {27'h000_0000, pm[k], 3'h3});
            far_u.send(11'h201, 10);
            far_u.send(11'h301, 10);
            chkSt(8'h03, 8'h01);
            pe0 = rd[ST_PE];
            apb(1'b0, ADDR_DATA, 32'h0000_0000);
            chkSt(8'h03, 8'h01);
            `CHK(pe0 ^ rd[ST_PE], 1'b1)
            if (k == 2) `CHK(rd[ST_PE], 1'b1)
            apb(1'b0, ADDR_DATA, 32'h0000_0000);
        end
        far_u.send(11'h301, 10);
        apb(1'b1, ADDR_CMD, 32'h0000_0020);
        chkSt(8'h03, 8'h00);
        apb(1'b1, ADDR_CMD, 32'h0000_0030);
        chkSt(8'h0C, 8'h00);
        closeOut();
    end
endmodule : uart_status_flags_tb
